/* hdl/sync_sel_pkg.sv */
// Register indices, field positions and reset values of the sync source select block.
package sync_sel_pkg;
	// ****************************************
	// Register indices (byte address is four times the index)
	// ****************************************
	localparam logic [5:0] IDX_USER_POL   = 6'h0F;
	localparam logic [5:0] IDX_DETECT     = 6'h11;
	localparam logic [5:0] IDX_SYNC_CTRL  = 6'h12;
	localparam logic [5:0] IDX_SEP_THRESH = 6'h13;
	localparam logic [5:0] IDX_AUX_CTRL   = 6'h14;
	localparam logic [5:0] IDX_POL_STAT   = 6'h15;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int HS_OVR    = 5;
	localparam int HS_SEL    = 4;
	localparam int VS_OVR    = 3;
	localparam int VS_SEL    = 2;
	localparam int COAST_SEL = 1;
	localparam int SLEEP_N   = 0;
	localparam int SCAN_EN   = 2;
	localparam int CPOL_OVR  = 1;
	localparam int HPOL_OVR  = 0;
	localparam int USR_HPOL  = 7;
	localparam int USR_CPOL  = 6;
	localparam int DET_HACT  = 7;
	localparam int DET_SACT  = 6;
	localparam int DET_HSEL  = 2;
	localparam int DET_VSEL  = 1;
	localparam int ST_CPOL   = 5;
	localparam int ST_VPOL   = 0;
	// ****************************************
	// Reset values and bus answers
	// ****************************************
	localparam logic [7:0] SYNC_CTRL_RST  = 8'h01;
	localparam logic [7:0] SEP_THRESH_RST = 8'h20;
	localparam logic [7:0] AUX_CTRL_RST   = 8'h18;
	localparam logic [7:0] USER_POL_RST   = 8'hC0;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;
endpackage

/* hdl/sync_separator.sv */
// Sync separator: the output follows the input only after it has differed for thresh clocks.
`timescale 1ns/10ps
`default_nettype none
module sync_separator #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	// Threshold and signal
	input  wire logic [W-1:0] thresh,
	input  wire logic         sync_in,
	output var  logic         sync_out
);
	// Elaboration stops here for a counter width that the compare cannot serve.
	if (W < 2 || W > 16) begin : g_bad_width
		$error("sync_separator: W out of range");
	end

	logic [W-1:0] run;
	logic [W-1:0] next_run;
	logic         next_out;

	// RL7 count before toggle
	always_comb begin
		next_run = '0;
		next_out = sync_out;
		if (sync_in != sync_out) begin
			if ({1'b0, run} + 1'b1 >= {1'b0, thresh}) begin
				next_out = sync_in;
			end else begin
				next_run = run + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run      <= '0;
			sync_out <= 1'b0;
		end else begin
			run      <= next_run;
			sync_out <= next_out;
		end
	end

	a_sep_filter: assert property (@(posedge core_clk) disable iff (!rst_n) // RL7
		$changed(sync_out) |-> ({1'b0, $past(run)} + 1'b1 >= {1'b0, $past(thresh)}))
		else $error("separator toggled before threshold");
endmodule // sync_separator
`default_nettype wire

/* hdl/sync_source_select_control.sv */
// Sync and coast source selection with its control registers on an AXI4-Lite slave.
// Function
// RL1 - Hsync override set: user select bit chooses hsync, else detection register.
// RL2 - Hsync select 0 picks hsync pin, 1 sync-on-green; also when both active.
// RL3 - Vsync override set: user select bit chooses vsync, else detection register.
// RL4 - Vsync select 0 routes raw vsync, 1 the separated vsync.
// RL5 - Coast select 0 uses coast pin, 1 uses the vsync signal.
// RL6 - Sleep bit low powers the chip down, high keeps normal operation.
// RL7 - Separator counts threshold clocks before toggling, rejecting shorter pulses.
// RL8 - Software sets threshold above the widest hsync or equalization pulse.
// RL9 - Threshold is an eight-bit read/write field resetting to 0x20.
// RL10 - Software writes 1 to control bits 4 and 3 for proper operation.
// RL11 - Scan enable bit disables scan at 0 and enables it at 1.
// RL12 - Coast polarity override 0 auto-detects, 1 follows the user polarity bit.
// RL13 - Hsync polarity override 0 auto-detects, 1 follows the user polarity bit.
// RL14 - Status bit 5 shows detected coast polarity, 1 meaning active high.
// RL15 - Status bit 0 shows vsync output polarity, 0 meaning active high.
// RL16 - Selection changes reach the multiplexers right after the write, no reset.
`timescale 1ns/10ps
`default_nettype none
module sync_source_select_control
	import sync_sel_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int POL_W  = 8
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	// AXI4-Lite write channels
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output var  logic              awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output var  logic              wready,
	output var  logic [1:0]        bresp,
	output var  logic              bvalid,
	input  wire logic              bready,
	// AXI4-Lite read channels
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output var  logic              arready,
	output var  logic [31:0]       rdata,
	output var  logic [1:0]        rresp,
	output var  logic              rvalid,
	input  wire logic              rready,
	// Sync pins
	input  wire logic              hsync_pin,
	input  wire logic              sog_pin,
	input  wire logic              vsync_pin,
	input  wire logic              coast_pin,
	// Detection results from the activity detector
	input  wire logic [7:0]        detect,
	// Selected outputs
	output var  logic              hsync_out,
	output var  logic              vsync_out,
	output var  logic              coast_out,
	output var  logic              chip_sleep_n,
	output var  logic              scan_en
);
	// Elaboration stops here when the decode or the polarity counters cannot be served.
	if (ADDR_W < 8 || POL_W < 2) begin : g_bad_param
		$error("sync_source_select_control: bad parameters");
	end

	// ****************************************
	// Reset release and pin synchronisers
	// ****************************************
	logic [1:0] rst_q;
	logic       rst_sync_n;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_q[1];

	logic [3:0] pin_raw;
	logic [3:0] pin_s;
	assign pin_raw = {coast_pin, vsync_pin, sog_pin, hsync_pin};
	// A level is accepted only when the second and third stages agree.
	for (genvar i = 0; i < 4; i++) begin : g_pin
		logic s1, s2, s3, val, next_val;
		always_comb begin
			next_val = (s2 == s3) ? s3 : val;
		end
		always_ff @(posedge core_clk or negedge rst_sync_n) begin
			if (!rst_sync_n) begin
				{s1, s2, s3, val} <= 4'h0;
			end else begin
				s1  <= pin_raw[i];
				s2  <= s1;
				s3  <= s2;
				val <= next_val;
			end
		end
		assign pin_s[i] = val;
	end

	// ****************************************
	// Register file and AXI4-Lite slave
	// ****************************************
	logic [7:0] user_pol, sync_ctrl, sep_thresh, aux_ctrl;
	logic [7:0] next_user_pol, next_sync_ctrl, next_sep_thresh, next_aux_ctrl;
	logic       aw_hold, w_hold, next_aw_hold, next_w_hold;
	logic [5:0] aw_idx, next_aw_idx;
	logic [7:0] w_byte, next_w_byte;
	logic       w_lane, next_w_lane;
	logic       next_awready, next_wready, next_arready, next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic [2:0] det_low;

	function automatic logic mapped(input logic [5:0] idx);
		return idx == IDX_USER_POL || idx == IDX_DETECT || idx == IDX_SYNC_CTRL
			|| idx == IDX_SEP_THRESH || idx == IDX_AUX_CTRL || idx == IDX_POL_STAT;
	endfunction

	logic [7:0] pol_stat;
	always_comb begin
		pol_stat = 8'h00;
		// RL14 coast polarity status
		pol_stat[ST_CPOL] = ~det_low[1];
		// RL15 vsync polarity status
		pol_stat[ST_VPOL] = det_low[2];
	end

	function automatic logic [7:0] read_reg(input logic [5:0] idx);
		if (idx == IDX_USER_POL) begin
			return user_pol;
		end else if (idx == IDX_DETECT) begin
			return detect;
		end else if (idx == IDX_SYNC_CTRL) begin
			return sync_ctrl;
		end else if (idx == IDX_SEP_THRESH) begin
			return sep_thresh;
		end else if (idx == IDX_AUX_CTRL) begin
			return aux_ctrl;
		end else if (idx == IDX_POL_STAT) begin
			return pol_stat;
		end else begin
			return 8'h00;
		end
	endfunction

	logic do_write;
	assign do_write = aw_hold && w_hold && !bvalid;

	always_comb begin
		next_user_pol   = user_pol;
		next_sync_ctrl  = sync_ctrl;
		next_sep_thresh = sep_thresh;
		next_aux_ctrl   = aux_ctrl;
		next_aw_hold    = aw_hold;
		next_w_hold     = w_hold;
		next_aw_idx     = aw_idx;
		next_w_byte     = w_byte;
		next_w_lane     = w_lane;
		next_bvalid     = bvalid;
		next_bresp      = bresp;
		next_rvalid     = rvalid;
		next_rdata      = rdata;
		next_rresp      = rresp;
		if (awvalid && awready) begin
			next_aw_hold = 1'b1;
			next_aw_idx  = awaddr[7:2];
		end
		if (wvalid && wready) begin
			next_w_hold = 1'b1;
			next_w_byte = wdata[7:0];
			next_w_lane = wstrb[0];
		end
		if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		// RL16 live selection write
		if (do_write) begin
			next_aw_hold = 1'b0;
			next_w_hold  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
			if (w_lane) begin
				if (aw_idx == IDX_USER_POL) begin
					next_user_pol = w_byte;
				end else if (aw_idx == IDX_SYNC_CTRL) begin
					next_sync_ctrl = w_byte;
				end else if (aw_idx == IDX_SEP_THRESH) begin
					// RL9 eight-bit threshold
					next_sep_thresh = w_byte;
				end else if (aw_idx == IDX_AUX_CTRL) begin
					next_aux_ctrl = w_byte;
				end
			end
		end
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rdata  = {24'h000000, read_reg(araddr[7:2])};
			next_rresp  = mapped(araddr[7:2]) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			next_rvalid = 1'b0;
		end
		next_awready = !next_aw_hold && !next_bvalid;
		next_wready  = !next_w_hold && !next_bvalid;
		next_arready = !next_rvalid;
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			user_pol   <= USER_POL_RST;
			sync_ctrl  <= SYNC_CTRL_RST;
			sep_thresh <= SEP_THRESH_RST;
			aux_ctrl   <= AUX_CTRL_RST;
			aw_hold    <= 1'b0;
			w_hold     <= 1'b0;
			aw_idx     <= 6'h00;
			w_byte     <= 8'h00;
			w_lane     <= 1'b0;
			awready    <= 1'b0;
			wready     <= 1'b0;
			arready    <= 1'b0;
			bvalid     <= 1'b0;
			bresp      <= RESP_OKAY;
			rvalid     <= 1'b0;
			rdata      <= 32'h00000000;
			rresp      <= RESP_OKAY;
		end else begin
			user_pol   <= next_user_pol;
			sync_ctrl  <= next_sync_ctrl;
			sep_thresh <= next_sep_thresh;
			aux_ctrl   <= next_aux_ctrl;
			aw_hold    <= next_aw_hold;
			w_hold     <= next_w_hold;
			aw_idx     <= next_aw_idx;
			w_byte     <= next_w_byte;
			w_lane     <= next_w_lane;
			awready    <= next_awready;
			wready     <= next_wready;
			arready    <= next_arready;
			bvalid     <= next_bvalid;
			bresp      <= next_bresp;
			rvalid     <= next_rvalid;
			rdata      <= next_rdata;
			rresp      <= next_rresp;
		end
	end

	// ****************************************
	// Source selection and polarity
	// ****************************************
	logic hs_user, hs_pick_sog, hs_lvl, vs_pick_sep, vs_lvl, coast_lvl, sep_vs;
	logic hs_low, coast_low, awake;
	logic next_hsync_out, next_vsync_out, next_coast_out, next_sleep_n, next_scan_en;

	sync_separator #(.W(8)) u_sep (
		.core_clk (core_clk),
		.rst_n    (rst_sync_n),
		.thresh   (sep_thresh),
		.sync_in  (hs_lvl),
		.sync_out (sep_vs)
	);

	always_comb begin
		awake = sync_ctrl[SLEEP_N];
		// RL1 hsync override
		hs_user = sync_ctrl[HS_OVR] || (detect[DET_HACT] && detect[DET_SACT]);
		hs_pick_sog = hs_user ? sync_ctrl[HS_SEL] : detect[DET_HSEL];
		// RL2 hsync or sync-on-green
		hs_lvl = hs_pick_sog ? pin_s[1] : pin_s[0];
		// RL3 vsync override
		vs_pick_sep = sync_ctrl[VS_OVR] ? sync_ctrl[VS_SEL] : detect[DET_VSEL];
		// RL4 raw or separated vsync
		vs_lvl = vs_pick_sep ? sep_vs : pin_s[2];
		// RL5 coast source
		coast_lvl = sync_ctrl[COAST_SEL] ? vs_lvl : pin_s[3];
		// RL12 coast polarity source
		coast_low = aux_ctrl[CPOL_OVR] ? !user_pol[USR_CPOL] : det_low[1];
		// RL13 hsync polarity source
		hs_low = aux_ctrl[HPOL_OVR] ? !user_pol[USR_HPOL] : det_low[0];
		// RL6 power-down gating
		next_sleep_n   = awake;
		next_hsync_out = awake && (hs_lvl ^ hs_low);
		next_vsync_out = awake && vs_lvl;
		next_coast_out = awake && (coast_lvl ^ coast_low);
		// RL11 scan enable
		next_scan_en   = aux_ctrl[SCAN_EN];
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			{hsync_out, vsync_out, coast_out, chip_sleep_n, scan_en} <= 5'h00;
		end else begin
			hsync_out    <= next_hsync_out;
			vsync_out    <= next_vsync_out;
			coast_out    <= next_coast_out;
			chip_sleep_n <= next_sleep_n;
			scan_en      <= next_scan_en;
		end
	end

	// A saturating up/down count per signal; the level that dominates is the idle level.
	logic [2:0] pol_src;
	assign pol_src = {vs_lvl, pin_s[3], hs_lvl};
	for (genvar i = 0; i < 3; i++) begin : g_pol
		logic [POL_W-1:0] cnt, next_cnt;
		always_comb begin
			next_cnt = cnt;
			if (pol_src[i] && cnt != '1) begin
				next_cnt = cnt + 1'b1;
			end else if (!pol_src[i] && cnt != '0) begin
				next_cnt = cnt - 1'b1;
			end
		end
		always_ff @(posedge core_clk or negedge rst_sync_n) begin
			if (!rst_sync_n) begin
				cnt <= '0;
			end else begin
				cnt <= next_cnt;
			end
		end
		assign det_low[i] = cnt[POL_W-1];
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_sync_n);

	sequence s_ctrl_write;
		do_write && w_lane && aw_idx == IDX_SYNC_CTRL;
	endsequence
	sequence s_aux_write;
		do_write && w_lane && aw_idx == IDX_AUX_CTRL;
	endsequence

	a_hsync_override: assert property ( // RL1
		(sync_ctrl[HS_OVR] && !sync_ctrl[HS_SEL] && awake && !hs_low) |=> hsync_out == $past(pin_s[0]))
		else $error("hsync override not honoured");
	a_hsync_detect: assert property ( // RL2
		(!sync_ctrl[HS_OVR] && !(detect[DET_HACT] && detect[DET_SACT]) && detect[DET_HSEL]
		&& awake && !hs_low) |=> hsync_out == $past(pin_s[1]))
		else $error("hsync detection choice not honoured");
	a_vsync_select: assert property ( // RL4
		(sync_ctrl[VS_OVR] && !sync_ctrl[VS_SEL] && awake) |=> vsync_out == $past(pin_s[2]))
		else $error("raw vsync not routed");
	a_vsync_auto: assert property ( // RL3
		(!sync_ctrl[VS_OVR] && detect[DET_VSEL] && awake) |=> vsync_out == $past(sep_vs))
		else $error("vsync detection choice not honoured");
	a_coast_pin: assert property ( // RL5
		(!sync_ctrl[COAST_SEL] && awake) |=> coast_out == $past(pin_s[3] ^ coast_low))
		else $error("coast pin not used");
	a_sleep_gate: assert property ( // RL6
		!sync_ctrl[SLEEP_N] |=> !chip_sleep_n && !hsync_out && !vsync_out && !coast_out)
		else $error("outputs active in power-down");
	a_thresh_reset: assert property ( // RL9
		$rose(rst_sync_n) |-> sep_thresh == SEP_THRESH_RST)
		else $error("threshold reset value wrong");
	a_scan_write: assert property ( // RL11
		s_aux_write |=> ##1 scan_en == $past(w_byte[SCAN_EN], 2))
		else $error("scan enable not following write");
	a_coast_pol: assert property ( // RL12
		(aux_ctrl[CPOL_OVR] && !sync_ctrl[COAST_SEL] && awake)
		|=> coast_out == $past(pin_s[3] ^ !user_pol[USR_CPOL]))
		else $error("coast user polarity ignored");
	a_hsync_pol: assert property ( // RL13
		(aux_ctrl[HPOL_OVR] && sync_ctrl[HS_OVR] && !sync_ctrl[HS_SEL] && awake)
		|=> hsync_out == $past(pin_s[0] ^ !user_pol[USR_HPOL]))
		else $error("hsync user polarity ignored");
	a_status_read: assert property ( // RL14
		(arvalid && arready && araddr[7:2] == IDX_POL_STAT)
		|=> rvalid && rdata[ST_CPOL] == $past(!det_low[1]) && rdata[ST_VPOL] == $past(det_low[2]))
		else $error("polarity status read wrong");
	a_select_live: assert property ( // RL16
		s_ctrl_write |=> sync_ctrl == $past(w_byte) ##1 chip_sleep_n == $past(sync_ctrl[SLEEP_N]))
		else $error("selection write not applied");
endmodule // sync_source_select_control
`default_nettype wire

/* tb/host_model.sv */
// Register bus master that plays the host controller in front of the block.
`timescale 1ns/10ps
`default_nettype none
module host_model (
	// Clock
	input  wire logic        core_clk,
	// Write channels
	output var  logic [7:0]  awaddr,
	output var  logic [2:0]  awprot,
	output var  logic        awvalid,
	input  wire logic        awready,
	output var  logic [31:0] wdata,
	output var  logic [3:0]  wstrb,
	output var  logic        wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output var  logic        bready,
	// Read channels
	output var  logic [7:0]  araddr,
	output var  logic [2:0]  arprot,
	output var  logic        arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output var  logic        rready
);
	initial begin
		{awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arprot, arvalid, rready} = '0;
	end

	// Address and data are offered together and each is released once taken.
	task automatic write_reg(input logic [5:0] idx, input logic [7:0] val,
		output logic [1:0] resp);
		logic aw_open;
		logic w_open;
		@(posedge core_clk);
		awaddr  <= {idx, 2'b00};
		wdata   <= {24'h000000, val};
		wstrb   <= 4'hF;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		aw_open = 1'b1;
		w_open  = 1'b1;
		while (aw_open || w_open) begin
			@(posedge core_clk);
			if (aw_open && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw_open = 1'b0;
			end
			if (w_open && wready === 1'b1) begin
				wvalid <= 1'b0;
				w_open = 1'b0;
			end
		end
		do @(posedge core_clk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic read_reg(input logic [5:0] idx, output logic [31:0] data,
		output logic [1:0] resp);
		@(posedge core_clk);
		araddr  <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge core_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge core_clk); while (rvalid !== 1'b1);
		data = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
endmodule // host_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the sync source select block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import sync_sel_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  awaddr, araddr, detect = 8'h00;
	logic [2:0]  awprot, arprot;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, stayed;
	logic [31:0] wdata, rdata, rd_val;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic        hsync_pin = 1'b0, sog_pin = 1'b0, vsync_pin = 1'b0, coast_pin = 1'b0;
	logic        hsync_out, vsync_out, coast_out, chip_sleep_n, scan_en;
	int          fail_count = 0, tests_run = 0, cycles = 0;
	logic [7:0]  hs_ctrl [6] = '{8'h21, 8'h31, 8'h01, 8'h01, 8'h11, 8'h01};
	logic [7:0]  hs_det  [6] = '{8'h04, 8'h00, 8'h04, 8'h00, 8'hC0, 8'hC4};
	logic        hs_exp  [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
	logic [7:0]  vs_ctrl [5] = '{8'h29, 8'h2D, 8'h21, 8'h21, 8'h2B};
	logic [7:0]  vs_det  [5] = '{8'h02, 8'h00, 8'h02, 8'h00, 8'h00};
	logic [1:0]  vs_exp  [5] = '{2'h2, 2'h0, 2'h0, 2'h2, 2'h3};

	always #5 core_clk = ~core_clk;

	host_model host (.core_clk, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready);
	sync_source_select_control #(.POL_W(3)) DUT (.core_clk, .rst_n, .awaddr, .awprot,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.hsync_pin, .sog_pin, .vsync_pin, .coast_pin, .detect, .hsync_out, .vsync_out,
		.coast_out, .chip_sleep_n, .scan_en);

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] val);
		host.write_reg(idx, val, resp);
	endtask
	task automatic rd(input string name, input logic [5:0] idx, input logic [31:0] exp);
		host.read_reg(idx, rd_val, resp);
		check(name, rd_val, exp);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Pulses of three clocks stay under the threshold of four, so they must be ignored.
	task automatic pulse(input logic lvl, output logic ok);
		hsync_pin <= lvl;
		settle(3);
		hsync_pin <= ~lvl;
		ok = 1'b1;
		repeat (16) begin
			@(posedge core_clk);
			if (vsync_out !== ~lvl)
				ok = 1'b0;
		end
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			print_verdict();
		end
	end

	initial begin
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		settle(4);
		check("chip_sleep_n", chip_sleep_n, 1);
		check("scan_en", scan_en, 0);
		rd("thresh reset", IDX_SEP_THRESH, 32'h20);
		rd("ctrl reset", IDX_SYNC_CTRL, 32'h01);
		rd("aux reset", IDX_AUX_CTRL, 32'h18);
		rd("user pol reset", IDX_USER_POL, 32'hC0);
		wr(IDX_SEP_THRESH, 8'hA5);
		check("write resp", resp, RESP_OKAY);
		rd("thresh rw", IDX_SEP_THRESH, 32'hA5);
		rd("unmapped", 6'h3F, 32'h0);
		check("unmapped resp", resp, RESP_SLVERR);
		wr(6'h3F, 8'h55);
		check("unmapped write resp", resp, RESP_SLVERR);
		$display("register test done");
		wr(IDX_AUX_CTRL, 8'h1B);
		wr(IDX_SEP_THRESH, 8'h04);
		hsync_pin <= 1'b1;
		foreach (hs_ctrl[i]) begin
			detect <= hs_det[i];
			wr(IDX_SYNC_CTRL, hs_ctrl[i]);
			settle(12);
			check("hsync_out", hsync_out, hs_exp[i]);
		end
		rd("detect read", IDX_DETECT, 32'hC4);
		hsync_pin <= 1'b0;
		sog_pin <= 1'b1;
		wr(IDX_SYNC_CTRL, 8'h31);
		settle(12);
		check("sog high", hsync_out, 1);
		$display("hsync select test done");
		hsync_pin <= 1'b0;
		sog_pin <= 1'b0;
		vsync_pin <= 1'b1;
		foreach (vs_ctrl[i]) begin
			detect <= vs_det[i];
			wr(IDX_SYNC_CTRL, vs_ctrl[i]);
			settle(16);
			check("vsync coast", {vsync_out, coast_out}, vs_exp[i]);
		end
		$display("vsync coast test done");
		wr(IDX_SYNC_CTRL, 8'h2D);
		settle(16);
		pulse(1'b1, stayed);
		check("short high pulse", stayed, 1);
		hsync_pin <= 1'b1;
		settle(16);
		check("long high", vsync_out, 1);
		pulse(1'b0, stayed);
		check("short low pulse", stayed, 1);
		$display("separator test done");
		coast_pin <= 1'b1;
		wr(IDX_SYNC_CTRL, 8'h21);
		wr(IDX_USER_POL, 8'h00);
		settle(16);
		check("user low pol", {hsync_out, coast_out}, 0);
		wr(IDX_USER_POL, 8'hC0);
		settle(16);
		check("user high pol", {hsync_out, coast_out}, 3);
		wr(IDX_AUX_CTRL, 8'h18);
		settle(24);
		check("auto pol", {hsync_out, coast_out}, 0);
		host.read_reg(IDX_POL_STAT, rd_val, resp);
		check("status idle high", rd_val & 32'h21, 32'h01);
		vsync_pin <= 1'b0;
		coast_pin <= 1'b0;
		settle(24);
		host.read_reg(IDX_POL_STAT, rd_val, resp);
		check("status idle low", rd_val & 32'h21, 32'h20);
		$display("polarity test done");
		wr(IDX_AUX_CTRL, 8'h1C);
		settle(2);
		check("scan on", scan_en, 1);
		wr(IDX_SYNC_CTRL, 8'h20);
		settle(2);
		check("sleep", {chip_sleep_n, scan_en}, 1);
		wr(IDX_SYNC_CTRL, 8'h21);
		wr(IDX_AUX_CTRL, 8'h18);
		settle(2);
		check("wake", {chip_sleep_n, scan_en}, 2);
		$display("sleep scan test done");
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
